// >>> dv/epw_bridge_model.sv
// Far-side model: the three fault sources and the bridge gate inputs.
// Assumes the bench raises faults on faultReq: bit 0 pin, bit 1 cmp1, bit 2 cmp2.
`timescale 1ns/100ps
module epw_bridge_model (
  // Device pins
  input wire logic [3:0] pwmOut,
  input wire logic [3:0] pwmOe,
  // Bench control
  input wire logic [2:0] faultReq,
  // Fault sources
  output logic faultInputPin,
  output logic comparator1,
  output logic comparator2,
  // Gate levels seen by the switches
  output logic [3:0] gateLevel
);
  assign faultInputPin = faultReq[0];
  assign comparator1 = faultReq[1];
  assign comparator2 = faultReq[2];
  // floating pins pulled low
  // Pull-downs keep the switches off whenever a pin is not driven
  assign gateLevel = pwmOut & pwmOe;
endmodule

// >>> dv/epw_pwm_sva.sv
// Checker for the PWM block ports: bus handshakes and reset state.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
module epw_pwm_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic faultInputPin,
  input wire logic comparator1,
  input wire logic comparator2,
  input wire logic [3:0] pwmOut,
  input wire logic [3:0] pwmOe,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Write taken then answered one cycle later
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not answered");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready && !s_axi_wready)
    else $error("address ready longer than one cycle");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // Reset leaves every pin an input
  reset_pins_a: assert property (disable iff (1'b0) reset |=> pwmOe == 4'h0 && !irq)
    else $error("pins driven after reset");
endmodule

bind epw_pwm_top epw_pwm_sva u_epw_pwm_sva (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .faultInputPin, .comparator1, .comparator2,
  .pwmOut, .pwmOe, .irq);

// >>> dv/epw_pwm_top_bench.sv
// Self-checking bench for the PWM block: registers, timer flag, shutdown.
// Assumes the bridge model beside the design and a 125 MHz clock.
`timescale 1ns/100ps
module epw_pwm_top_bench;
  typedef struct {logic [5:0] a; logic wr; logic [7:0] d; logic [7:0] e;} epw_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid, irq, fPin, cmp1, cmp2;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [3:0] pwmOut, pwmOe, gateLevel;
  logic [2:0] faultReq = 3'h0;
  int miscompares = 0, check_count = 0;
  // Ordinary cases: reset values first, then write and read back
  epw_row_t rows [19] = '{
    '{6'h00, 0, 8'h00, 8'h00}, '{6'h04, 0, 8'h00, 8'h00}, // timer reset
    '{6'h08, 0, 8'h00, 8'hFF}, '{6'h0C, 0, 8'h00, 8'h00}, // period all ones
    '{6'h10, 0, 8'h00, 8'h00}, '{6'h14, 0, 8'h00, 8'h00}, // control defaults
    '{6'h18, 0, 8'h00, 8'h00}, '{6'h1C, 0, 8'h00, 8'h00}, // shutdown defaults
    '{6'h20, 0, 8'h00, 8'h00}, '{6'h24, 0, 8'h00, 8'h00}, // flags clear
    '{6'h28, 0, 8'h00, 8'h0F}, '{6'h04, 1, 8'h03, 8'h03}, // inputs, prescale
    '{6'h08, 1, 8'h10, 8'h10}, '{6'h0C, 1, 8'hA5, 8'hA5}, // period, duty
    '{6'h14, 1, 8'h3C, 8'h3C}, '{6'h1C, 1, 8'h7F, 8'h7F}, // fields
    '{6'h10, 1, 8'h55, 8'h00}, '{6'h28, 1, 8'h05, 8'h05}, // read only, direction
    '{6'h24, 1, 8'h03, 8'h03}};
  always #4 clk = ~clk;
  epw_pwm_top u_epw_pwm_top (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .faultInputPin(fPin), .comparator1(cmp1), .comparator2(cmp2), .pwmOut(pwmOut),
    .pwmOe(pwmOe), .irq(irq));
  epw_bridge_model u_epw_bridge_model (.pwmOut(pwmOut), .pwmOe(pwmOe), .faultReq(faultReq),
    .faultInputPin(fPin), .comparator1(cmp1), .comparator2(cmp2), .gateLevel(gateLevel));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // Start on a fresh edge so no signal is assigned twice in one step
  task automatic axw(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) begin
        awvalid <= 1'b0;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    r = bresp;
    if (n >= 100) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 100) begin
      miscompares++;
      complete_run();
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic e;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    chk("pwmOe", 4'h0, pwmOe);
    foreach (rows[i]) begin
      if (rows[i].wr)
        axw(rows[i].a, rows[i].d, rs);
      axr(rows[i].a, rd, rs);
      chk($sformatf("reg %h", rows[i].a), {24'h000000, rows[i].e}, rd);
    end
    // Unmapped word answers with an error and reads zero
    axw(6'h2C, 8'hFF, rs);
    chk("bresp", 2'h2, rs);
    axr(6'h2C, rd, rs);
    chk("rresp", 2'h2, rs);
    chk("rdata", 32'h0, rd);
    // Reset in mid-run restores defaults
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    axr(6'h08, rd, rs);
    chk("period", 32'hFF, rd);
    axr(6'h28, rd, rs);
    chk("direction", 32'hF, rd);
    // Overflow flag with the interrupt masked, then unmasked, then cleared
    axw(6'h08, 8'h03, rs);
    axw(6'h04, 8'h04, rs);
    repeat (40) @(posedge clk);
    chk("irq masked", 1'b0, irq);
    for (int k = 0; k < 4; k++) begin
      axr(6'h00, rd, rs);
      chk("count in period", 1'b1, rd <= 32'h3);
    end
    axw(6'h24, 8'h02, rs);
    repeat (3) @(posedge clk);
    chk("irq", 1'b1, irq);
    axw(6'h04, 8'h00, rs);
    axr(6'h20, rd, rs);
    chk("overflow flag", 32'h2, rd & 32'h2);
    axw(6'h20, 8'h02, rs);
    axr(6'h20, rd, rs);
    chk("flag cleared", 32'h0, rd);
    repeat (3) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    // setup order: zero, sources, run, outputs after overflow
    axw(6'h18, 8'h00, rs);
    axw(6'h18, 8'h46, rs);
    axw(6'h14, 8'h8C, rs);
    axw(6'h04, 8'h04, rs);
    n = 0;
    do begin
      axr(6'h20, rd, rs);
      n++;
    end while (rd[1] !== 1'b1 && n < 50);
    chk("new period", 1'b1, rd[1]);
    axw(6'h28, 8'h00, rs);
    axw(6'h18, 8'h46, rs);
    // Fault pin: A driven high, B/C/D floating, status refuses writes
    @(posedge clk);
    faultReq <= 3'h1;
    repeat (8) @(posedge clk);
    chk("gate A", 1'b1, gateLevel[0]);
    chk("pin B driven", 1'b0, pwmOe[1]);
    axw(6'h18, 8'h46, rs);
    axr(6'h18, rd, rs);
    chk("status set", 32'hC6, rd);
    faultReq <= 3'h0;
    repeat (8) @(posedge clk);
    axr(6'h18, rd, rs);
    chk("status held", 32'hC6, rd);
    // Long period so the hold after the clear is visible
    axw(6'h08, 8'hFF, rs);
    axw(6'h18, 8'h46, rs);
    axr(6'h18, rd, rs);
    chk("status cleared", 32'h46, rd);
    chk("shut to period end", 1'b0, pwmOe[1]);
    repeat (270) @(posedge clk);
    chk("resumed at period", 1'b1, gateLevel[1]);
    axw(6'h18, 8'hC6, rs);
    axr(6'h18, rd, rs);
    chk("status forced", 32'hC6, rd);
    // Every source code against every source, restart on
    axw(6'h1C, 8'h80, rs);
    for (int s = 0; s < 8; s++) begin
      for (int f = 0; f < 3; f++) begin
        axw(6'h18, {1'b0, s[2:0], 4'h0}, rs);
        e = (f == 0) ? s[2] : (f == 1) ? s[0] : s[1];
        faultReq <= 3'h1 << f;
        repeat (8) @(posedge clk);
        axr(6'h18, rd, rs);
        chk($sformatf("src %0d on %0d", s, f), e, rd[7]);
        faultReq <= 3'h0;
        repeat (8) @(posedge clk);
        axr(6'h18, rd, rs);
        chk("auto restart", 1'b0, rd[7]);
      end
    end
    // Single output, A/C inverted, zero duty: only A driven, and high
    axw(6'h14, 8'h0E, rs);
    repeat (300) @(posedge clk);
    chk("single pins", 4'h1, pwmOe);
    chk("A inverted", 1'b1, gateLevel[0]);
    complete_run();
  end
endmodule

// >>> src/epw_pwm_top.v
// Enhanced PWM channel: period timer, duty compare, dead band, auto-shutdown.
// Assumes clk is the instruction clock and fault/comparator inputs are asynchronous.
//
// Behaviour
// - Any reset makes every PWM pin an input and returns all registers to defaults.
// - The PWM period comes from the period register, which resets to all ones.
// - The duty value is the low duty byte joined with control bits 5 and 4.
// - In half-bridge mode the dead band comes from delay config bits 6 to 0.
// - Delay config bit 7 enables automatic restart after the shutdown cause ends.
// - Shutdown status sits at bit 7 of shutdown control and software may write it.
// - A three-bit source field picks the fault pin and comparators for shutdown.
// - Two two-bit fields give the shutdown state of pairs A/C and B/D.
// - Control top bits give output configuration, low four bits give mode/polarity.
// - Timer control bits 1:0 pick the prescale and bit 2 runs the timer.
// - Timer overflow sets flag bit 1 of the flag register, which software clears.
// - Source codes: 0 off, 1 cmp1, 2 cmp2, 3 either, 4 pin, 5-7 pin or comparators.
// - Pair state codes: 00 drive low, 01 drive high, 1x tri-state.
// - With restart the status clears when the cause ends, else software clears it.
// - Outputs leave shutdown only at the start of the next PWM period.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "epw_regs.vh"

module epw_pwm_top (
  // Clock and reset
  input wire clk,
  input wire reset,
  // AXI4-Lite write
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Fault sources
  input wire faultInputPin,
  input wire comparator1,
  input wire comparator2,
  // PWM pins, index 0..3 = a, b, c, d
  output reg [3:0] pwmOut,
  output reg [3:0] pwmOe,
  // Interrupt
  output reg irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Drive level of a pair in shutdown; 1x means tri-state
  function shutLevel;
    input [1:0] sel;
    begin
      shutLevel = sel[0];
    end
  endfunction

  // Pin level from an active flag and an active-low polarity bit
  function polarize;
    input act;
    input invert;
    begin
      polarize = act ^ invert;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] periodTimerCount_reg, periodTimerPeriod_reg, dutyCycleLow_reg, dutyCycleHigh_reg;
  reg [6:0] periodTimerControl_reg;
  reg [7:0] channelControl_reg, autoShutdownControl_reg, deadbandRestartConfig_reg;
  reg [1:0] peripheralFlagReg1_reg, irqMask_reg, dutyFine_reg;
  reg [3:0] pinDirection_reg, prescale_reg, postscale_reg;
  reg shutHold_reg, rawPrev_reg;
  reg [6:0] deadband_reg;
  reg [2:0] syncA_reg, syncB_reg;

  // ----------------------------------------------------------------
  // Fault input synchronisers
  // ----------------------------------------------------------------
  // Two stages each; only stage B feeds logic
  always @(posedge clk) begin
    if (reset) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
    end else begin
      syncA_reg <= {faultInputPin, comparator2, comparator1};
      syncB_reg <= syncA_reg;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire wrByte = wrFire && s_axi_wstrb[0];
  wire [7:0] wrData = s_axi_wdata[7:0];
  wire rdFire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  // Address hit for a write of the low byte
  function wrHit;
    input [5:0] off;
    input [5:0] addr;
    begin
      wrHit = (addr == off);
    end
  endfunction

  wire wCount = wrByte && wrHit(`EPW_OFF_COUNT, s_axi_awaddr);
  wire wTctrl = wrByte && wrHit(`EPW_OFF_TCTRL, s_axi_awaddr);
  wire wPeriod = wrByte && wrHit(`EPW_OFF_PERIOD, s_axi_awaddr);
  wire wDutyLo = wrByte && wrHit(`EPW_OFF_DUTYLO, s_axi_awaddr);
  wire wChctrl = wrByte && wrHit(`EPW_OFF_CHCTRL, s_axi_awaddr);
  wire wAsctrl = wrByte && wrHit(`EPW_OFF_ASCTRL, s_axi_awaddr);
  wire wDbcfg = wrByte && wrHit(`EPW_OFF_DBCFG, s_axi_awaddr);
  wire wFlags = wrByte && wrHit(`EPW_OFF_FLAGS, s_axi_awaddr);
  wire wMask = wrByte && wrHit(`EPW_OFF_MASK, s_axi_awaddr);
  wire wPindir = wrByte && wrHit(`EPW_OFF_PINDIR, s_axi_awaddr);

  // ----------------------------------------------------------------
  // Period timer
  // ----------------------------------------------------------------
  wire timerRun = periodTimerControl_reg[`EPW_TC_RUN];
  wire [1:0] preSel = periodTimerControl_reg[`EPW_TC_PRE_HI:`EPW_TC_PRE_LO];
  wire [3:0] postSel = periodTimerControl_reg[`EPW_TC_POST_HI:`EPW_TC_POST_LO];
  // prescale decode: 1, 4 or 16
  wire [3:0] preTop = (preSel == 2'h0) ? 4'h0 : (preSel == 2'h1) ? 4'h3 : 4'hF;
  wire tick = timerRun && (prescale_reg == preTop);
  wire periodEnd = tick && (periodTimerCount_reg == periodTimerPeriod_reg);
  wire overflow = periodEnd && (postscale_reg == postSel);

  // Timer, prescaler and postscaler; a count write also clears the prescaler
  always @(posedge clk) begin
    if (reset) begin
      periodTimerCount_reg <= `EPW_RST_ZERO;
      prescale_reg <= 4'h0;
      postscale_reg <= 4'h0;
    end else if (wCount) begin
      periodTimerCount_reg <= wrData;
      prescale_reg <= 4'h0;
    end else if (timerRun) begin
      prescale_reg <= tick ? 4'h0 : prescale_reg + 4'h1;
      if (periodEnd) begin
        periodTimerCount_reg <= 8'h00;
        postscale_reg <= overflow ? 4'h0 : postscale_reg + 4'h1;
      end else if (tick) begin
        periodTimerCount_reg <= periodTimerCount_reg + 8'h01;
      end
    end
  end

  // Fine duty bits come from the prescaler phase, as far as it is divided
  wire [1:0] fine = (preSel == 2'h0) ? 2'h0 :
                    (preSel == 2'h1) ? prescale_reg[1:0] : prescale_reg[3:2];

  // ----------------------------------------------------------------
  // Shutdown source and status
  // ----------------------------------------------------------------
  wire [2:0] srcSel = autoShutdownControl_reg[`EPW_AS_SRC_HI:`EPW_AS_SRC_LO];
  wire cause = (srcSel[0] && syncB_reg[0]) || (srcSel[1] && syncB_reg[1]) ||
               (srcSel[2] && syncB_reg[2]);
  wire status = autoShutdownControl_reg[`EPW_AS_STAT];
  wire restartEn = deadbandRestartConfig_reg[`EPW_DB_RESTART];

  // Control registers; status bit set by a cause wins over any write
  always @(posedge clk) begin
    if (reset) begin
      // defaults leave the channel out of PWM mode with no pin driven
      periodTimerControl_reg <= 7'h00;
      periodTimerPeriod_reg <= `EPW_RST_PERIOD;
      dutyCycleLow_reg <= `EPW_RST_ZERO;
      channelControl_reg <= `EPW_RST_ZERO;
      autoShutdownControl_reg <= `EPW_RST_ZERO;
      deadbandRestartConfig_reg <= `EPW_RST_ZERO;
      irqMask_reg <= 2'h0;
      pinDirection_reg <= `EPW_RST_PINDIR;
    end else begin
      if (wTctrl) periodTimerControl_reg <= wrData[6:0];
      if (wPeriod) periodTimerPeriod_reg <= wrData;
      if (wDutyLo) dutyCycleLow_reg <= wrData;
      if (wChctrl) channelControl_reg <= wrData;
      if (wDbcfg) deadbandRestartConfig_reg <= wrData;
      if (wMask) irqMask_reg <= wrData[1:0];
      if (wPindir) pinDirection_reg <= wrData[3:0];
      if (wAsctrl) autoShutdownControl_reg[6:0] <= wrData[6:0];
      // software write, ignored while a cause is present
      if (cause)
        autoShutdownControl_reg[`EPW_AS_STAT] <= 1'b1;
      else if (wAsctrl)
        autoShutdownControl_reg[`EPW_AS_STAT] <= wrData[`EPW_AS_STAT];
      // automatic clear once the cause is gone
      else if (restartEn)
        autoShutdownControl_reg[`EPW_AS_STAT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Duty latch and period hold of shutdown
  // ----------------------------------------------------------------
  // ten-bit duty, latched at period start so edits never glitch a period
  wire [9:0] dutyNow = {dutyCycleHigh_reg, dutyFine_reg};
  always @(posedge clk) begin
    if (reset) begin
      dutyCycleHigh_reg <= `EPW_RST_ZERO;
      dutyFine_reg <= 2'h0;
      shutHold_reg <= 1'b0;
    end else begin
      if (periodEnd) begin
        dutyCycleHigh_reg <= dutyCycleLow_reg;
        dutyFine_reg <= channelControl_reg[`EPW_CC_DC_HI:`EPW_CC_DC_LO];
      end
      // stay shut for any period begun while status is set
      if (status)
        shutHold_reg <= 1'b1;
      else if (periodEnd)
        shutHold_reg <= 1'b0;
    end
  end
  wire shutNow = status || shutHold_reg;

  // ----------------------------------------------------------------
  // Modulation and dead band
  // ----------------------------------------------------------------
  wire [3:0] mode = channelControl_reg[`EPW_CC_MODE_HI:`EPW_CC_MODE_LO];
  wire [1:0] cfg = channelControl_reg[`EPW_CC_CFG_HI:`EPW_CC_CFG_LO];
  // upper mode bits 11 select PWM
  wire pwmMode = (mode[3:2] == 2'h3);
  wire raw = ({periodTimerCount_reg, fine} < dutyNow);
  wire [6:0] dbCount = deadbandRestartConfig_reg[`EPW_DB_CNT_HI:0];

  // Counter restarts on every raw edge; the going-active output waits for it
  always @(posedge clk) begin
    if (reset) begin
      deadband_reg <= 7'h00;
      rawPrev_reg <= 1'b0;
    end else begin
      rawPrev_reg <= raw;
      if (raw != rawPrev_reg)
        deadband_reg <= 7'h00;
      else if (deadband_reg != dbCount)
        deadband_reg <= deadband_reg + 7'h01;
    end
  end
  wire dbDone = (raw == rawPrev_reg) && (deadband_reg == dbCount);

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  reg [3:0] act, used, pinNext, oeNext;
  wire [1:0] stAc = autoShutdownControl_reg[`EPW_AS_AC_HI:`EPW_AS_AC_LO];
  wire [1:0] stBd = autoShutdownControl_reg[`EPW_AS_BD_HI:`EPW_AS_BD_LO];

  // Output mapping per configuration, then polarity, shutdown and direction
  always @* begin
    act = 4'h0;
    used = 4'h0;
    case (cfg)
      `EPW_CFG_SINGLE: begin
        act = {3'h0, raw};
        used = 4'h1;
      end
      `EPW_CFG_FWD: begin
        act = {raw, 2'h0, 1'b1};
        used = 4'hF;
      end
      `EPW_CFG_HALF: begin
        act = {2'h0, !raw && dbDone, raw && dbDone};
        used = 4'h3;
      end
      `EPW_CFG_REV: begin
        act = {1'b0, 1'b1, raw, 1'b0};
        used = 4'hF;
      end
      default: act = 4'h0;
    endcase
    // polarity: bit 1 inverts pair A/C, bit 0 inverts pair B/D
    pinNext[0] = polarize(act[0], mode[1]);
    pinNext[2] = polarize(act[2], mode[1]);
    pinNext[1] = polarize(act[1], mode[0]);
    pinNext[3] = polarize(act[3], mode[0]);
    oeNext = used;
    if (!pwmMode) begin
      pinNext = 4'h0;
      oeNext = 4'h0;
    end else if (shutNow) begin
      pinNext = {shutLevel(stBd), shutLevel(stAc), shutLevel(stBd), shutLevel(stAc)};
      oeNext = {!stBd[1], !stAc[1], !stBd[1], !stAc[1]} & used;
    end
    // direction bit set keeps the pin an input
    oeNext = oeNext & ~pinDirection_reg;
  end

  always @(posedge clk) begin
    if (reset) begin
      pwmOut <= 4'h0;
      pwmOe <= 4'h0;
    end else begin
      pwmOut <= pinNext;
      pwmOe <= oeNext;
    end
  end

  // ----------------------------------------------------------------
  // Event flags and interrupt
  // ----------------------------------------------------------------
  // overflow flag; write one clears, a same-cycle event wins
  wire shutRise = cause && !status;
  always @(posedge clk) begin
    if (reset) begin
      peripheralFlagReg1_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      peripheralFlagReg1_reg[`EPW_FL_OVF] <= overflow ||
        (peripheralFlagReg1_reg[`EPW_FL_OVF] && !(wFlags && wrData[`EPW_FL_OVF]));
      peripheralFlagReg1_reg[`EPW_FL_SHUT] <= shutRise ||
        (peripheralFlagReg1_reg[`EPW_FL_SHUT] && !(wFlags && wrData[`EPW_FL_SHUT]));
      irq <= |(peripheralFlagReg1_reg & irqMask_reg);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg [7:0] rdByte;
  reg rdOk;
  // Read mux; unmapped offsets answer with an error and zero data
  always @* begin
    rdOk = 1'b1;
    rdByte = 8'h00;
    case (s_axi_araddr)
      `EPW_OFF_COUNT: rdByte = periodTimerCount_reg;
      `EPW_OFF_TCTRL: rdByte = {1'b0, periodTimerControl_reg};
      `EPW_OFF_PERIOD: rdByte = periodTimerPeriod_reg;
      `EPW_OFF_DUTYLO: rdByte = dutyCycleLow_reg;
      `EPW_OFF_DUTYHI: rdByte = dutyCycleHigh_reg;
      `EPW_OFF_CHCTRL: rdByte = channelControl_reg;
      `EPW_OFF_ASCTRL: rdByte = autoShutdownControl_reg;
      `EPW_OFF_DBCFG: rdByte = deadbandRestartConfig_reg;
      `EPW_OFF_FLAGS: rdByte = {6'h00, peripheralFlagReg1_reg};
      `EPW_OFF_MASK: rdByte = {6'h00, irqMask_reg};
      `EPW_OFF_PINDIR: rdByte = {4'h0, pinDirection_reg};
      default: rdOk = 1'b0;
    endcase
  end

  // Write address and data are taken together, one cycle after both are valid
  wire wrMapped = (s_axi_awaddr <= `EPW_OFF_PINDIR) && (s_axi_awaddr[1:0] == 2'h0);
  always @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EPW_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `EPW_RESP_OK;
      s_axi_rdata <= 32'h00000000;
    end else begin
      s_axi_awready <= wrFire;
      s_axi_wready <= wrFire;
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `EPW_RESP_OK : `EPW_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rdFire;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdOk ? `EPW_RESP_OK : `EPW_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> src/epw_regs.vh
// Register map, field positions, reset values and encodings of the enhanced PWM block.
// Assumes a byte-addressed AXI4-Lite slave with one 32-bit word per register.
`ifndef EPW_REGS_VH
`define EPW_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EPW_OFF_COUNT 6'h00
`define EPW_OFF_TCTRL 6'h04
`define EPW_OFF_PERIOD 6'h08
`define EPW_OFF_DUTYLO 6'h0C
`define EPW_OFF_DUTYHI 6'h10
`define EPW_OFF_CHCTRL 6'h14
`define EPW_OFF_ASCTRL 6'h18
`define EPW_OFF_DBCFG 6'h1C
`define EPW_OFF_FLAGS 6'h20
`define EPW_OFF_MASK 6'h24
`define EPW_OFF_PINDIR 6'h28

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EPW_RST_PERIOD 8'hFF
`define EPW_RST_ZERO 8'h00
`define EPW_RST_PINDIR 4'hF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EPW_TC_RUN 2
`define EPW_TC_PRE_HI 1
`define EPW_TC_PRE_LO 0
`define EPW_TC_POST_HI 6
`define EPW_TC_POST_LO 3
`define EPW_CC_CFG_HI 7
`define EPW_CC_CFG_LO 6
`define EPW_CC_DC_HI 5
`define EPW_CC_DC_LO 4
`define EPW_CC_MODE_HI 3
`define EPW_CC_MODE_LO 0
`define EPW_AS_STAT 7
`define EPW_AS_SRC_HI 6
`define EPW_AS_SRC_LO 4
`define EPW_AS_AC_HI 3
`define EPW_AS_AC_LO 2
`define EPW_AS_BD_HI 1
`define EPW_AS_BD_LO 0
`define EPW_DB_RESTART 7
`define EPW_DB_CNT_HI 6
`define EPW_FL_OVF 1
`define EPW_FL_SHUT 0

// ----------------------------------------------------------------
// Encodings and bus answers
// ----------------------------------------------------------------
`define EPW_CFG_SINGLE 2'h0
`define EPW_CFG_FWD 2'h1
`define EPW_CFG_HALF 2'h2
`define EPW_CFG_REV 2'h3
`define EPW_RESP_OK 2'h0
`define EPW_RESP_ERR 2'h2

`endif
